/* qeo_pkg.sv */
/*
  Constants and carrier types for the quadrature encoder output block.
  Assumes a 100 MHz system clock and a phase word that covers one signal period.
*/
package qeo_pkg;

  // ----------------------------------------
  // Clock and widths
  // ----------------------------------------
  localparam int CLK_NS = 10;
  localparam int PHASE_W = 12;
  localparam int POS_W = 32;
  localparam int GAP_W = 8;
  localparam int FCODE_W = 4;
  localparam logic [POS_W-1:0] LAG_MAX = 32'h0000_0400;

  // ----------------------------------------
  // Variants of the switch tracks
  // ----------------------------------------
  localparam logic [1:0] VAR_TWO_SWITCH = 2'h0;
  localparam logic [1:0] VAR_SEL_REF = 2'h1;
  localparam logic [1:0] VAR_NO_SWITCH = 2'h2;

  // ----------------------------------------
  // Minimum edge separation per factor
  // ----------------------------------------
  localparam int GAP_X1_NS = 500;
  localparam int GAP_X2_NS = 250;
  localparam int GAP_X5_NS = 300;
  localparam int GAP_X10_NS = 300;
  localparam int GAP_X20_NS = 200;
  localparam int GAP_X25_NS = 200;
  localparam int GAP_X50_NS = 100;
  localparam int GAP_X100_NS = 100;
  localparam int GAP_X200_NS = 50;
  localparam logic [GAP_W-1:0] GAP_X1_CYC = GAP_W'((GAP_X1_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [GAP_W-1:0] GAP_X2_CYC = GAP_W'((GAP_X2_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [GAP_W-1:0] GAP_X5_CYC = GAP_W'((GAP_X5_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [GAP_W-1:0] GAP_X10_CYC = GAP_W'((GAP_X10_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [GAP_W-1:0] GAP_X20_CYC = GAP_W'((GAP_X20_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [GAP_W-1:0] GAP_X25_CYC = GAP_W'((GAP_X25_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [GAP_W-1:0] GAP_X50_CYC = GAP_W'((GAP_X50_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [GAP_W-1:0] GAP_X100_CYC = GAP_W'((GAP_X100_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [GAP_W-1:0] GAP_X200_CYC = GAP_W'((GAP_X200_NS + CLK_NS - 1) / CLK_NS);

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    QEO_Q0 = 2'h0,
    QEO_Q1 = 2'h1,
    QEO_Q2 = 2'h3,
    QEO_Q3 = 2'h2
  } qeo_quad_type;

  typedef struct packed {
    logic pos;
    logic neg;
  } qeo_diff_type;

  typedef struct packed {
    logic started;
    logic [FCODE_W-1:0] fcode;
    logic [1:0] lastQuad;
    logic signed [POS_W-1:0] period;
    logic signed [POS_W-1:0] outCount;
    logic [GAP_W-1:0] gapCnt;
    qeo_quad_type quad;
    logic refPrev;
    logic refValid;
    logic signed [POS_W-1:0] refPos;
    logic lostPhase;
    qeo_diff_type trackA;
    qeo_diff_type trackB;
    qeo_diff_type refOut;
    qeo_diff_type faultOut;
    logic sw1;
    logic sw2;
  } qeo_state_type;

endpackage : qeo_pkg

/* qeo_sync.sv */
/*
  Three-stage input synchroniser with agreement filter.
  Assumes asynchronous pin inputs and one system clock.
*/
`timescale 1ns/1ps
module qeo_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] stage1_ff;
  logic [W-1:0] stage2_ff;
  logic [W-1:0] stage3_ff;
  logic [W-1:0] out_ff;

  // ----------------------------------------
  // Stages; a change counts once stages two and three agree
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
      stage3_ff <= '0;
      out_ff <= '0;
    end else begin
      stage1_ff <= din;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
      for (int i = 0; i < W; i++) begin
        if (stage2_ff[i] == stage3_ff[i]) begin
          out_ff[i] <= stage3_ff[i];
        end
      end
    end
  end

  assign dout = out_ff;

endmodule : qeo_sync

/* qeo_top.sv */
/*
  Digital output side of an incremental encoder scanning head: interpolator,
  quadrature track generation, reference pulse, fault and switch outputs.
  Assumes a phase word from the analog front end on clk, pins for the
  reference and switch tracks, and an RS-422 line driver fed by the pairs.
*/
// What this block does
// - Two tracks offset by a quarter period
// - Divide each period by fixed factor
// - One measuring step between consecutive edges
// - Minimum edge spacing set by factor
// - Reference pulse one increment, both directions
// - Fault output on faulty scanning signals
// - Selectable variant: one switch, second qualifies
// - No-switch variant: switch pins without function
// - Track, reference and fault outputs as differential pairs for RS-422
`timescale 1ns/1ps
module qeo_top
  import qeo_pkg::*;
#(
  parameter logic [1:0] VARIANT = VAR_TWO_SWITCH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [FCODE_W-1:0] factorSel,
  input wire logic [PHASE_W-1:0] phaseIn,
  input wire logic signalBad,
  input wire logic refMarkPin,
  input wire logic switchTrackOnePin,
  input wire logic switchTrackTwoPin,
  output qeo_diff_type quad_track_a,
  output qeo_diff_type quad_track_b,
  output qeo_diff_type ref_pulse,
  output qeo_diff_type fault_output,
  output logic switch_output_one,
  output logic switch_output_two
);

  // ----------------------------------------
  // Factor decode
  // ----------------------------------------
  function automatic logic [7:0] factorOf(input logic [FCODE_W-1:0] code);
    unique case (code)
      4'h0: factorOf = 8'h01;
      4'h1: factorOf = 8'h02;
      4'h2: factorOf = 8'h05;
      4'h3: factorOf = 8'h0A;
      4'h4: factorOf = 8'h14;
      4'h5: factorOf = 8'h19;
      4'h6: factorOf = 8'h32;
      4'h7: factorOf = 8'h64;
      default: factorOf = 8'hC8;
    endcase
  endfunction : factorOf

  function automatic logic [GAP_W-1:0] gapOf(input logic [FCODE_W-1:0] code);
    unique case (code)
      4'h0: gapOf = GAP_X1_CYC;
      4'h1: gapOf = GAP_X2_CYC;
      4'h2: gapOf = GAP_X5_CYC;
      4'h3: gapOf = GAP_X10_CYC;
      4'h4: gapOf = GAP_X20_CYC;
      4'h5: gapOf = GAP_X25_CYC;
      4'h6: gapOf = GAP_X50_CYC;
      4'h7: gapOf = GAP_X100_CYC;
      default: gapOf = GAP_X200_CYC;
    endcase
  endfunction : gapOf

  function automatic qeo_quad_type quadStep(input qeo_quad_type q, input logic up);
    unique case (q)
      QEO_Q0: quadStep = up ? QEO_Q1 : QEO_Q3;
      QEO_Q1: quadStep = up ? QEO_Q2 : QEO_Q0;
      QEO_Q2: quadStep = up ? QEO_Q3 : QEO_Q1;
      QEO_Q3: quadStep = up ? QEO_Q0 : QEO_Q2;
    endcase
  endfunction : quadStep

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] pinSync;

  qeo_sync #(
    .W(3)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din({switchTrackTwoPin, switchTrackOnePin, refMarkPin}),
    .dout(pinSync)
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  qeo_state_type state_ff;
  qeo_state_type nxt_state;
  logic [7:0] factor;
  logic [PHASE_W+7:0] subProd;
  logic signed [POS_W-1:0] target;
  logic signed [POS_W-1:0] diff;
  logic [POS_W-1:0] lag;
  logic [1:0] quadIn;
  logic refQual;
  logic wrapUp;
  logic wrapDown;
  logic signed [POS_W-1:0] periodNow;

  assign factor = factorOf(state_ff.fcode);
  assign subProd = phaseIn * factor;
  assign quadIn = phaseIn[PHASE_W-1:PHASE_W-2];
  // Period unwrap applied in the same cycle as the new phase, so a wrap makes no false step
  assign wrapUp = state_ff.started && (state_ff.lastQuad == 2'h3) && (quadIn == 2'h0);
  assign wrapDown = state_ff.started && (state_ff.lastQuad == 2'h0) && (quadIn == 2'h3);
  assign periodNow = wrapUp ? state_ff.period + 32'sh1 : (wrapDown ? state_ff.period - 32'sh1 : state_ff.period);
  assign target = POS_W'(periodNow * $signed({1'b0, factor})) + $signed(POS_W'(subProd[PHASE_W+7:PHASE_W]));
  assign diff = target - state_ff.outCount;
  assign lag = diff[POS_W-1] ? POS_W'(-diff) : POS_W'(diff);
  assign refQual = (VARIANT == VAR_SEL_REF) ? pinSync[2] : 1'b1;

  always_comb begin
    nxt_state = state_ff;
    // Factor is a strap, taken once after reset release
    if (!state_ff.started) begin
      nxt_state.started = 1'b1;
      nxt_state.fcode = factorSel;
      nxt_state.lastQuad = quadIn;
    end else begin
      // Period unwrap from the phase quadrant
      nxt_state.lastQuad = quadIn;
      nxt_state.period = periodNow;
      if ((state_ff.lastQuad ^ quadIn) == 2'h2) begin
        nxt_state.lostPhase = 1'b1;
      end
      // One edge per step, spaced by the minimum separation
      if (state_ff.gapCnt != '0) begin
        nxt_state.gapCnt = state_ff.gapCnt - GAP_W'(1);
      end else if (diff != '0) begin
        nxt_state.outCount = diff[POS_W-1] ? state_ff.outCount - 32'sh1 : state_ff.outCount + 32'sh1;
        nxt_state.quad = quadStep(state_ff.quad, !diff[POS_W-1]);
        nxt_state.gapCnt = gapOf(state_ff.fcode) - GAP_W'(1);
      end
      // Reference mark capture
      nxt_state.refPrev = pinSync[0];
      if (pinSync[0] && !state_ff.refPrev && refQual) begin
        nxt_state.refValid = 1'b1;
        nxt_state.refPos = target;
      end
    end
    nxt_state.trackA.pos = nxt_state.quad[0];
    nxt_state.trackA.neg = !nxt_state.quad[0];
    nxt_state.trackB.pos = nxt_state.quad[1];
    nxt_state.trackB.neg = !nxt_state.quad[1];
    nxt_state.refOut.pos = nxt_state.refValid && (nxt_state.outCount == nxt_state.refPos);
    nxt_state.refOut.neg = !nxt_state.refOut.pos;
    nxt_state.faultOut.pos = state_ff.started && (signalBad || state_ff.lostPhase || (lag > LAG_MAX));
    nxt_state.faultOut.neg = !nxt_state.faultOut.pos;
    nxt_state.sw1 = (VARIANT == VAR_NO_SWITCH) ? 1'b0 : pinSync[1];
    nxt_state.sw2 = (VARIANT == VAR_TWO_SWITCH) ? pinSync[2] : 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '{started: 1'b0, fcode: '0, lastQuad: 2'h0, period: '0, outCount: '0,
                    gapCnt: '0, quad: QEO_Q0, refPrev: 1'b0, refValid: 1'b0, refPos: '0,
                    lostPhase: 1'b0, trackA: 2'h1, trackB: 2'h1, refOut: 2'h1,
                    faultOut: 2'h1, sw1: 1'b0, sw2: 1'b0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign quad_track_a = state_ff.trackA;
  assign quad_track_b = state_ff.trackB;
  assign ref_pulse = state_ff.refOut;
  assign fault_output = state_ff.faultOut;
  assign switch_output_one = state_ff.sw1;
  assign switch_output_two = state_ff.sw2;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [GAP_W-1:0] sinceEdge_ff;
  logic edgeNow;
  assign edgeNow = (state_ff.trackA.pos != nxt_state.trackA.pos) || (state_ff.trackB.pos != nxt_state.trackB.pos);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sinceEdge_ff <= 8'hFF;
    end else if (edgeNow) begin
      sinceEdge_ff <= 8'h01;
    end else if (sinceEdge_ff != 8'hFF) begin
      sinceEdge_ff <= sinceEdge_ff + 8'h01;
    end
  end

  property p_quarter;
    @(posedge clk) disable iff (!rst_n)
      !($changed(quad_track_a.pos) && $changed(quad_track_b.pos));
  endproperty
  a_quarter: assert property (p_quarter) else $error("Both tracks changed together");

  property p_step;
    @(posedge clk) disable iff (!rst_n)
      ($changed(quad_track_a.pos) || $changed(quad_track_b.pos)) |->
        (state_ff.outCount - $past(state_ff.outCount) == 32'sh1) ||
        ($past(state_ff.outCount) - state_ff.outCount == 32'sh1);
  endproperty
  a_step: assert property (p_step) else $error("Edge did not move count by one step");

  property p_toward;
    @(posedge clk) disable iff (!rst_n)
      (state_ff.started && diff > 0 && state_ff.gapCnt == '0) |=> (state_ff.outCount == $past(state_ff.outCount) + 32'sh1);
  endproperty
  a_toward: assert property (p_toward) else $error("Count did not follow interpolated target");

  property p_spacing;
    @(posedge clk) disable iff (!rst_n)
      edgeNow |-> (sinceEdge_ff >= gapOf(state_ff.fcode));
  endproperty
  a_spacing: assert property (p_spacing) else $error("Edges closer than minimum separation");

  property p_ref;
    @(posedge clk) disable iff (!rst_n)
      ref_pulse.pos |-> (state_ff.refValid && state_ff.outCount == state_ff.refPos);
  endproperty
  a_ref: assert property (p_ref) else $error("Reference pulse off its increment");

  property p_fault;
    @(posedge clk) disable iff (!rst_n)
      (state_ff.started && signalBad) |=> fault_output.pos;
  endproperty
  a_fault: assert property (p_fault) else $error("Fault not raised on bad signal");

  property p_selref;
    @(posedge clk) disable iff (!rst_n)
      (VARIANT == VAR_SEL_REF) |-> !switch_output_two;
  endproperty
  a_selref: assert property (p_selref) else $error("Second switch active in selectable variant");

  property p_noswitch;
    @(posedge clk) disable iff (!rst_n)
      (VARIANT == VAR_NO_SWITCH) |-> (!switch_output_one && !switch_output_two);
  endproperty
  a_noswitch: assert property (p_noswitch) else $error("Switch output active without tracks");

  property p_diff;
    @(posedge clk) disable iff (!rst_n)
      (quad_track_a.neg == !quad_track_a.pos) && (quad_track_b.neg == !quad_track_b.pos) &&
      (ref_pulse.neg == !ref_pulse.pos) && (fault_output.neg == !fault_output.pos);
  endproperty
  a_diff: assert property (p_diff) else $error("Differential pair not complementary");

endmodule : qeo_top

/* qeo_counter_model.sv */
/*
  Counting partner of the encoder output: follows every track edge, presets on the reference pulse.
  Assumes the same clock as the block and registered differential outputs.
*/
`timescale 1ns/1ps
module qeo_counter_model
  import qeo_pkg::*;
#(
  parameter int PRESET = 1000
) (
  input wire logic clk,
  input wire logic rst_n,
  input qeo_diff_type trackA,
  input qeo_diff_type trackB,
  input qeo_diff_type refP,
  output int position,
  output int minGap,
  output int refRises,
  output logic badStep,
  output logic diffBad
);
  int gap;
  logic prevA;
  logic prevB;
  logic refPrev;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      position <= 0;
      gap <= 1000;
      minGap <= 1000;
      refRises <= 0;
      badStep <= 1'b0;
      diffBad <= 1'b0;
      prevA <= 1'b0;
      prevB <= 1'b0;
      refPrev <= 1'b0;
    end else begin
      gap <= gap + 1;
      prevA <= trackA.pos;
      prevB <= trackB.pos;
      refPrev <= refP.pos;
      if (trackA.neg !== ~trackA.pos || trackB.neg !== ~trackB.pos || refP.neg !== ~refP.pos) begin
        diffBad <= 1'b1;
      end
      if (trackA.pos !== prevA || trackB.pos !== prevB) begin
        gap <= 1;
        if (gap < minGap) begin
          minGap <= gap;
        end
        if (trackA.pos !== prevA && trackB.pos !== prevB) begin
          badStep <= 1'b1;
        end else if (!(prevA ^ trackB.pos)) begin
          position <= position + 1;
        end else begin
          position <= position - 1;
        end
      end
      if (refP.pos && !refPrev) begin
        position <= PRESET;
        refRises <= refRises + 1;
      end
    end
  end
endmodule : qeo_counter_model

/* qeo_top_test.sv */
/*
  Self-checking testbench of the encoder output block at factors ten and two hundred.
  Assumes the counting partner model and three variants of the block.
*/
`timescale 1ns/1ps
module qeo_top_test
  import qeo_pkg::*;
;
  localparam int PRE = 1000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [FCODE_W-1:0] factorSel = 4'h3;
  logic [PHASE_W-1:0] phaseIn = 12'h000;
  logic signalBad = 1'b0;
  logic refMarkPin = 1'b0;
  logic swPin1 = 1'b0;
  logic swPin2 = 1'b0;
  qeo_diff_type trA, trB, refP, flt, selRef;
  logic sw1, sw2, selSw1, selSw2, noSw1, noSw2;
  int position, minGap, refRises, error_cnt, n_compared, tpos;
  logic badStep, diffBad;

  always #5 clk = ~clk;

  qeo_top DUT (.clk(clk), .rst_n(rst_n), .factorSel(factorSel), .phaseIn(phaseIn), .signalBad(signalBad),
    .refMarkPin(refMarkPin), .switchTrackOnePin(swPin1), .switchTrackTwoPin(swPin2), .quad_track_a(trA),
    .quad_track_b(trB), .ref_pulse(refP), .fault_output(flt), .switch_output_one(sw1), .switch_output_two(sw2));
  qeo_top #(.VARIANT(VAR_SEL_REF)) DUT_SEL (.clk(clk), .rst_n(rst_n), .factorSel(factorSel), .phaseIn(phaseIn),
    .signalBad(signalBad), .refMarkPin(refMarkPin), .switchTrackOnePin(swPin1), .switchTrackTwoPin(swPin2),
    .quad_track_a(), .quad_track_b(), .ref_pulse(selRef), .fault_output(), .switch_output_one(selSw1),
    .switch_output_two(selSw2));
  qeo_top #(.VARIANT(VAR_NO_SWITCH)) DUT_NOSW (.clk(clk), .rst_n(rst_n), .factorSel(factorSel), .phaseIn(phaseIn),
    .signalBad(signalBad), .refMarkPin(refMarkPin), .switchTrackOnePin(swPin1), .switchTrackTwoPin(swPin2),
    .quad_track_a(), .quad_track_b(), .ref_pulse(), .fault_output(), .switch_output_one(noSw1),
    .switch_output_two(noSw2));
  qeo_counter_model #(.PRESET(PRE)) partner (.clk(clk), .rst_n(rst_n), .trackA(trA), .trackB(trB), .refP(refP),
    .position(position), .minGap(minGap), .refRises(refRises), .badStep(badStep), .diffBad(diffBad));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask : chk

  task automatic move(input int n, input int dir);
    repeat (n) begin
      @(posedge clk);
      tpos += dir;
      phaseIn <= 12'(tpos * 512);
      repeat (3) @(posedge clk);
    end
    repeat (600) @(posedge clk);
  endtask : move

  task automatic tally_and_finish;
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset;
    chk(trA.pos === 1'b0 && trA.neg === 1'b1 && trB.neg === 1'b1 && flt.pos === 1'b0, "reset levels");
    $display("test_reset done");
  endtask : test_reset

  task automatic test_forward;
    move(8, 1);
    chk(position === 10, "forward count");
    chk(minGap >= int'(GAP_X10_CYC), "edge spacing");
    chk(badStep === 1'b0, "tracks not in quadrature");
    chk(diffBad === 1'b0, "pair not complementary");
    $display("test_forward done");
  endtask : test_forward

  task automatic test_reverse;
    move(3, -1);
    chk(position === 6, "reverse count");
    $display("test_reverse done");
  endtask : test_reverse

  task automatic test_reference;
    refMarkPin <= 1'b1;
    repeat (8) @(posedge clk);
    refMarkPin <= 1'b0;
    repeat (8) @(posedge clk);
    chk(refP.pos === 1'b1, "ref pulse missing");
    chk(position === PRE, "preset on ref");
    chk(selRef.pos === 1'b0, "unselected reference mark taken");
    move(3, 1);
    chk(refP.pos === 1'b0, "ref pulse too wide");
    chk(position === PRE + 4, "count after ref");
    move(3, -1);
    chk(refRises === 2 && refP.pos === 1'b1, "ref in reverse");
    chk(position === PRE, "preset in reverse");
    $display("test_reference done");
  endtask : test_reference

  task automatic test_fault;
    signalBad <= 1'b1;
    repeat (3) @(posedge clk);
    chk(flt.pos === 1'b1 && flt.neg === 1'b0, "fault not raised");
    signalBad <= 1'b0;
    repeat (3) @(posedge clk);
    chk(flt.pos === 1'b0, "fault not cleared");
    $display("test_fault done");
  endtask : test_fault

  task automatic test_switch;
    swPin1 <= 1'b1;
    swPin2 <= 1'b0;
    repeat (8) @(posedge clk);
    chk(sw1 === 1'b1 && sw2 === 1'b0 && selSw1 === 1'b1, "switch one");
    chk(noSw1 === 1'b0 && noSw2 === 1'b0, "no-switch variant one");
    swPin1 <= 1'b0;
    swPin2 <= 1'b1;
    repeat (8) @(posedge clk);
    chk(sw1 === 1'b0 && sw2 === 1'b1 && selSw2 === 1'b0, "switch two");
    chk(noSw1 === 1'b0 && noSw2 === 1'b0, "no-switch variant two");
    refMarkPin <= 1'b1;
    repeat (8) @(posedge clk);
    refMarkPin <= 1'b0;
    repeat (8) @(posedge clk);
    chk(selRef.pos === 1'b1, "selected reference mark ignored");
    $display("test_switch done");
  endtask : test_switch

  task automatic test_lost_phase;
    phaseIn <= phaseIn + 12'h800;
    repeat (4) @(posedge clk);
    chk(flt.pos === 1'b1, "lost phase fault");
    repeat (50) @(posedge clk);
    chk(flt.pos === 1'b1, "lost phase not sticky");
    rst_n <= 1'b0;
    phaseIn <= 12'h000;
    factorSel <= 4'h8;
    repeat (2) @(posedge clk);
    chk(flt.pos === 1'b0 && flt.neg === 1'b1 && refP.neg === 1'b1, "fault after reset");
    rst_n <= 1'b1;
    $display("test_lost_phase done");
  endtask : test_lost_phase

  task automatic test_strap;
    repeat (2) @(posedge clk);
    tpos = 0;
    move(2, 1);
    chk(position === 50, "count at factor two hundred");
    chk(minGap >= int'(GAP_X200_CYC), "spacing at factor two hundred");
    chk(badStep === 1'b0 && flt.pos === 1'b0, "quadrature or fault at factor two hundred");
    $display("test_strap done");
  endtask : test_strap

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    error_cnt = 0;
    n_compared = 0;
    tpos = 0;
    repeat (16) @(posedge clk);
    test_reset();
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    test_forward();
    test_reverse();
    test_reference();
    test_fault();
    test_switch();
    test_lost_phase();
    test_strap();
    tally_and_finish();
  end

  initial begin
    #200000;
    error_cnt++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule : qeo_top_test
